//--- common/wkev_regs.vh
/*
 * Register offsets, field positions and reset values of the wakeup event register bank.
 * Assumes byte-wide registers behind an 8-bit address port.
 */
`ifndef WKEV_REGS_VH
`define WKEV_REGS_VH

`define WKEV_ADDR_W 8
`define WKEV_DATA_W 8

`define WKEV_OFS_FLAGS 8'h00
`define WKEV_OFS_ENABLES 8'h01
`define WKEV_OFS_BANKCFG 8'h02
`define WKEV_OFS_INT_STAT 8'h10
`define WKEV_OFS_INT_MASK 8'h11
`define WKEV_OFS_CTRL 8'h12
`define WKEV_OFS_LINES 8'h13

`define WKEV_BIT_CODEC 0
`define WKEV_BIT_RING 1
`define WKEV_BIT_IR 5

`define WKEV_EVT_MASK 8'h23
`define WKEV_CFG_SEL_MASK 8'h03
`define WKEV_CFG_SEL_SHARED 2'h0
`define WKEV_CFG_SEL_BANK1 2'h1

`define WKEV_CTRL_SOFT_RST 0
`define WKEV_CTRL_ROUTE_PU 1
`define WKEV_CTRL_ROUTE_PME 2
`define WKEV_CTRL_MASK 8'h06

`define WKEV_RST_FLAGS 8'h00
`define WKEV_RST_ENABLES 8'h03
`define WKEV_RST_BANKCFG 8'h00
`define WKEV_RST_INT_STAT 8'h00
`define WKEV_RST_INT_MASK 8'h00
`define WKEV_RST_CTRL 8'h06

`endif

//--- design/wkev_sync.v
/*
 * Three-stage synchroniser with agreement filter for one asynchronous pin.
 * Assumes the pin is quasi-static compared with the 100 ns clock.
 */
`default_nettype none

module wkev_sync #(
    parameter RESET_LEVEL = 1'b1
) (
    input wire clock,
    input wire sys_rst,
    input wire pin_in,
    output reg level_r
);

    reg meta_r;
    reg sync2_r;
    reg sync3_r;

    // Only the second stage reads the first; the filter looks at stages two and three.
    always @(posedge clock) begin
        if (sys_rst) begin
            meta_r <= RESET_LEVEL;
            sync2_r <= RESET_LEVEL;
            sync3_r <= RESET_LEVEL;
            level_r <= RESET_LEVEL;
        end else begin
            meta_r <= pin_in;
            sync2_r <= meta_r;
            sync3_r <= sync2_r;
            if (sync2_r == sync3_r) begin
                level_r <= sync3_r;
            end
        end
    end

endmodule

`default_nettype wire

//--- design/wkev_top.v
/*
 * Wakeup event register bank: sticky event flags, event enables, bank select
 * configuration, wake request outputs and a maskable interrupt.
 * Assumes a simple register port master that follows the one-cycle strobe
 * protocol and wake pins that are asynchronous to clock.
 */
`include "wkev_regs.vh"

`default_nettype none

// Behaviour
// - Sticky flag bit 5 sets on infrared receive event, clears to 0 by default.
// - Sticky flag bit 1 sets on ring indicator event, default 0.
// - Sticky flag bit 0 sets on codec serial input event, default 0.
// - Enable register at 01h loads 03h on power-up and software reset.
// - Enabled detected events raise power-up request and/or PME; disabled ones raise neither.
// - Enable bit 5 gates infrared wake events, default disabled.
// - Enable bit 1 gates ring indicator wake events, default enabled.
// - Enable bit 0 gates codec wake events, default enabled.
// - Bank config at 02h resets to 00h and controls infrared bank reachability.
// - Flag register clears to 00h on power-up and software reset.
// - Flag register sits at 00h, is readable, and writing 1 clears a flag.
// - Config bits 1:0 value 00 shares only, 01 adds infrared bank.
module wkev_top (
    input wire clock,
    input wire sys_rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_r,
    input wire infrared_rx_input,
    input wire ring_indicator_two_n,
    input wire codec_serial_in_two,
    output reg wake_any_r,
    output reg power_up_req_r,
    output reg pme_r,
    output reg bank1_access_r,
    output reg irq_r
);

    wire ir_level;
    wire ring_level_n;
    wire codec_level;
    wire [2:0] pin_vec;
    wire [2:0] level_vec;

    reg ir_prev_r;
    reg ring_prev_r;
    reg codec_prev_r;

    reg [7:0] flags_r;
    reg [7:0] flags_nxt;
    reg [7:0] enables_r;
    reg [7:0] enables_nxt;
    reg [7:0] bankcfg_r;
    reg [7:0] bankcfg_nxt;
    reg [7:0] int_stat_r;
    reg [7:0] int_stat_nxt;
    reg [7:0] int_mask_r;
    reg [7:0] int_mask_nxt;
    reg [7:0] ctrl_r;
    reg [7:0] ctrl_nxt;
    reg [7:0] rdata_nxt;

    wire ir_event;
    wire ring_event;
    wire codec_event;
    wire [7:0] event_vec;
    wire [7:0] armed_vec;
    wire wake_nxt;
    wire soft_rst;
    wire wr_flags;
    wire wr_enables;
    wire wr_bankcfg;
    wire wr_int_stat;
    wire wr_int_mask;
    wire wr_ctrl;

    assign pin_vec = {codec_serial_in_two, ring_indicator_two_n, infrared_rx_input};

    // Idle level of each pin: infrared and ring idle high, the codec line idles low.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            wkev_sync #(
                .RESET_LEVEL((gi == 2) ? 1'b0 : 1'b1)
            ) u_sync (
                .clock(clock),
                .sys_rst(sys_rst),
                .pin_in(pin_vec[gi]),
                .level_r(level_vec[gi])
            );
        end
    endgenerate

    assign ir_level = level_vec[0];
    assign ring_level_n = level_vec[1];
    assign codec_level = level_vec[2];

    always @(posedge clock) begin
        if (sys_rst) begin
            ir_prev_r <= 1'b1;
            ring_prev_r <= 1'b1;
            codec_prev_r <= 1'b0;
        end else begin
            ir_prev_r <= ir_level;
            ring_prev_r <= ring_level_n;
            codec_prev_r <= codec_level;
        end
    end

    // An infrared burst starts with a low pulse on an idle-high receiver.
    assign ir_event = ir_prev_r & ~ir_level;
    // The ring indicator is active low, so its falling edge is the event.
    assign ring_event = ring_prev_r & ~ring_level_n;
    // A codec asks for wake by driving its serial data line high.
    assign codec_event = ~codec_prev_r & codec_level;

    assign event_vec = {2'b00, ir_event, 3'b000, ring_event, codec_event};

    // Flags that are both latched and enabled request wake.
    assign armed_vec = flags_r & enables_r & `WKEV_EVT_MASK;
    assign wake_nxt = |armed_vec;

    assign wr_flags = reg_wr & (reg_addr == `WKEV_OFS_FLAGS);
    assign wr_enables = reg_wr & (reg_addr == `WKEV_OFS_ENABLES);
    assign wr_bankcfg = reg_wr & (reg_addr == `WKEV_OFS_BANKCFG);
    assign wr_int_stat = reg_wr & (reg_addr == `WKEV_OFS_INT_STAT);
    assign wr_int_mask = reg_wr & (reg_addr == `WKEV_OFS_INT_MASK);
    assign wr_ctrl = reg_wr & (reg_addr == `WKEV_OFS_CTRL);

    // Software reset is a self-clearing strobe; it loads the power-up values of flags, enables and bank config.
    assign soft_rst = wr_ctrl & reg_wdata[`WKEV_CTRL_SOFT_RST];

    always @* begin
        flags_nxt = flags_r;
        if (wr_flags) begin
            flags_nxt = flags_nxt & ~reg_wdata;
        end
        // A new event in the clearing cycle is kept, so set goes last.
        flags_nxt = (flags_nxt | event_vec) & `WKEV_EVT_MASK;
        if (soft_rst) begin
            flags_nxt = `WKEV_RST_FLAGS;
        end
    end

    always @* begin
        enables_nxt = enables_r;
        if (wr_enables) begin
            // Bits 5, 1 and 0 gate infrared, ring and codec events.
            enables_nxt = reg_wdata & `WKEV_EVT_MASK;
        end
        if (soft_rst) begin
            enables_nxt = `WKEV_RST_ENABLES;
        end
    end

    always @* begin
        bankcfg_nxt = bankcfg_r;
        if (wr_bankcfg) begin
            // Reserved bits are not stored, so a careless write cannot leave them set.
            bankcfg_nxt = reg_wdata & `WKEV_CFG_SEL_MASK;
        end
        if (soft_rst) begin
            bankcfg_nxt = `WKEV_RST_BANKCFG;
        end
    end

    always @* begin
        int_stat_nxt = int_stat_r;
        if (wr_int_stat) begin
            int_stat_nxt = int_stat_nxt & ~reg_wdata;
        end
        int_stat_nxt = (int_stat_nxt | event_vec) & `WKEV_EVT_MASK;
    end

    always @* begin
        int_mask_nxt = int_mask_r;
        if (wr_int_mask) begin
            int_mask_nxt = reg_wdata & `WKEV_EVT_MASK;
        end
    end

    always @* begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = reg_wdata & `WKEV_CTRL_MASK;
        end
    end

    // Unmapped offsets, including the infrared bank handled elsewhere, read as zero.
    always @* begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `WKEV_OFS_FLAGS: rdata_nxt = flags_r;
                `WKEV_OFS_ENABLES: rdata_nxt = enables_r;
                `WKEV_OFS_BANKCFG: rdata_nxt = bankcfg_r;
                `WKEV_OFS_INT_STAT: rdata_nxt = int_stat_r;
                `WKEV_OFS_INT_MASK: rdata_nxt = int_mask_r;
                `WKEV_OFS_CTRL: rdata_nxt = ctrl_r;
                `WKEV_OFS_LINES: rdata_nxt = {5'h00, codec_level, ring_level_n, ir_level};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            flags_r <= `WKEV_RST_FLAGS;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            enables_r <= `WKEV_RST_ENABLES;
        end else begin
            enables_r <= enables_nxt;
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            bankcfg_r <= `WKEV_RST_BANKCFG;
        end else begin
            bankcfg_r <= bankcfg_nxt;
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            int_stat_r <= `WKEV_RST_INT_STAT;
        end else begin
            int_stat_r <= int_stat_nxt;
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            int_mask_r <= `WKEV_RST_INT_MASK;
        end else begin
            int_mask_r <= int_mask_nxt;
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            ctrl_r <= `WKEV_RST_CTRL;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata_r <= 8'h00;
        end else begin
            reg_rdata_r <= rdata_nxt;
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            wake_any_r <= 1'b0;
        end else begin
            wake_any_r <= wake_nxt;
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            power_up_req_r <= 1'b0;
        end else begin
            power_up_req_r <= wake_nxt & ctrl_r[`WKEV_CTRL_ROUTE_PU];
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            pme_r <= 1'b0;
        end else begin
            pme_r <= wake_nxt & ctrl_r[`WKEV_CTRL_ROUTE_PME];
        end
    end

    // Only select code 01 opens the infrared bank.
    always @(posedge clock) begin
        if (sys_rst) begin
            bank1_access_r <= 1'b0;
        end else begin
            bank1_access_r <= (bankcfg_r[1:0] == `WKEV_CFG_SEL_BANK1);
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(int_stat_r & int_mask_r);
        end
    end

endmodule

`default_nettype wire

//--- tb/wkev_top_asserts.sv
/* Port checker for the wakeup event register bank.
   Assumes it is bound to wkev_top and sees only that module's ports. */
`default_nettype none
module wkev_top_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata_r,
    input wire logic wake_any_r,
    input wire logic power_up_req_r,
    input wire logic pme_r,
    input wire logic bank1_access_r,
    input wire logic irq_r
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // The wake checks assume no pin event is in flight when software acts.
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata_r == 8'h00)
        else $error("read data not idle");
    chk_unmapped_read: assert property (reg_rd && reg_addr >= 8'h03 && reg_addr <= 8'h0F
        |=> reg_rdata_r == 8'h00) else $error("unmapped read not zero");
    chk_reset_quiet: assert property ($fell(sys_rst) |-> !wake_any_r && !pme_r
        && !irq_r && !bank1_access_r) else $error("outputs active after reset");
    chk_bank_open: assert property (reg_wr && reg_addr == 8'h02 && reg_wdata[1:0] == 2'b01
        |-> ##[1:2] bank1_access_r) else $error("bank not opened");
    chk_bank_closed: assert property (reg_wr && reg_addr == 8'h02
        && reg_wdata[1:0] != 2'b01 |-> ##[1:2] !bank1_access_r) else $error("bank not closed");
    chk_pme_wake: assert property (pme_r |-> wake_any_r) else $error("pme without wake");
    chk_pu_wake: assert property (power_up_req_r |-> wake_any_r)
        else $error("power-up request without wake");
    chk_enable_back: assert property (reg_wr && reg_addr == 8'h01 ##2 reg_rd
        && reg_addr == 8'h01 |=> reg_rdata_r == ($past(reg_wdata, 3) & 8'h23))
        else $error("enable readback wrong");
    chk_wake_off: assert property (reg_wr && reg_addr == 8'h01 && reg_wdata == 8'h00
        |-> ##2 !wake_any_r) else $error("wake stayed with enables off");
    chk_soft_quiet: assert property (reg_wr && reg_addr == 8'h12 && reg_wdata[0]
        |-> ##2 !wake_any_r && !pme_r) else $error("wake stayed after soft reset");
    cov_wake: cover property ($rose(wake_any_r));
    cov_irq: cover property ($rose(irq_r));
    cov_bank: cover property ($rose(bank1_access_r));
endmodule
bind wkev_top wkev_top_chk u_wkev_top_chk (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .wake_any_r(wake_any_r), .power_up_req_r(power_up_req_r),
    .pme_r(pme_r), .bank1_access_r(bank1_access_r), .irq_r(irq_r));
`default_nettype wire

//--- tb/wkev_top_test.sv
/* Self-checking bench for the wakeup event register bank.
   Assumes wkev_top with its bound checker; pins sit idle unless pulsed. */
`default_nettype none
module wkev_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic infrared_rx_input = 1'b1;
    logic ring_indicator_two_n = 1'b1;
    logic codec_serial_in_two = 1'b0;
    wire [7:0] reg_rdata_r;
    wire wake_any_r, power_up_req_r, pme_r, bank1_access_r, irq_r;
    int bad_count = 0;
    int samples_checked = 0;
    // Rows of offset, write data, expected readback; reserved bits must read back as 0.
    logic [23:0] rows [11] = '{24'h01BF23, 24'h012020, 24'h02E703, 24'h020101, 24'h075500,
        24'h13FF03, 24'h120000, 24'h120606, 24'h112323, 24'h010303, 24'h020000};
    wkev_top u_wkev_top (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .infrared_rx_input(infrared_rx_input), .ring_indicator_two_n(ring_indicator_two_n),
        .codec_serial_in_two(codec_serial_in_two), .wake_any_r(wake_any_r),
        .power_up_req_r(power_up_req_r), .pme_r(pme_r), .bank1_access_r(bank1_access_r),
        .irq_r(irq_r));
    initial begin
        forever #50 clock = ~clock;
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata_r, exp);
    endtask
    // Pins pass a synchroniser, so allow a fixed margin beyond its latency.
    task settle;
        repeat (8) @(posedge clock);
        #1;
    endtask
    task test_done;
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        test_done;
    end
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h03);
        rd(8'h02, 8'h00);
        for (int i = 0; i < 11; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        @(posedge clock);
        ring_indicator_two_n <= 1'b0;
        settle;
        chk({5'h00, wake_any_r, power_up_req_r, pme_r}, 8'h07);
        @(posedge clock);
        ring_indicator_two_n <= 1'b1;
        rd(8'h00, 8'h02);
        wr(8'h00, 8'h02);
        rd(8'h00, 8'h00);
        settle;
        chk({5'h00, wake_any_r, power_up_req_r, pme_r}, 8'h00);
        @(posedge clock);
        infrared_rx_input <= 1'b0;
        settle;
        chk({5'h00, wake_any_r, power_up_req_r, pme_r}, 8'h00);
        @(posedge clock);
        infrared_rx_input <= 1'b1;
        rd(8'h00, 8'h20);
        chk({7'h00, irq_r}, 8'h01);
        wr(8'h11, 8'h00);
        settle;
        chk({7'h00, irq_r}, 8'h00);
        wr(8'h01, 8'h23);
        settle;
        chk({5'h00, wake_any_r, power_up_req_r, pme_r}, 8'h07);
        wr(8'h12, 8'h02);
        settle;
        chk({5'h00, wake_any_r, power_up_req_r, pme_r}, 8'h06);
        wr(8'h12, 8'h04);
        settle;
        chk({5'h00, wake_any_r, power_up_req_r, pme_r}, 8'h05);
        wr(8'h02, 8'h01);
        settle;
        chk({7'h00, bank1_access_r}, 8'h01);
        wr(8'h02, 8'h02);
        settle;
        chk({7'h00, bank1_access_r}, 8'h00);
        wr(8'h02, 8'h01);
        wr(8'h12, 8'h07);
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h03);
        rd(8'h02, 8'h00);
        wr(8'h01, 8'h00);
        @(posedge clock);
        codec_serial_in_two <= 1'b1;
        settle;
        chk({5'h00, wake_any_r, power_up_req_r, pme_r}, 8'h00);
        chk({7'h00, bank1_access_r}, 8'h00);
        @(posedge clock);
        codec_serial_in_two <= 1'b0;
        rd(8'h00, 8'h01);
        wr(8'h01, 8'h01);
        settle;
        chk({5'h00, wake_any_r, power_up_req_r, pme_r}, 8'h07);
        rd(8'h10, 8'h23);
        wr(8'h10, 8'h23);
        rd(8'h10, 8'h00);
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h03);
        chk({5'h00, wake_any_r, power_up_req_r, pme_r}, 8'h00);
        test_done;
    end
endmodule
`default_nettype wire
